// ===== src/serial_dac_word_port.sv
// Serial word port of a current-output converter: package, system-clock side and Wishbone slave.
// Assumes a classic Wishbone master on SYS_CLK and a host driving SCLK, FRAME_N and the input line.
// Summary of operation
// RL1 - Power-up samples on falling edge; code selects rising
// RL2 - Shift sixteen input bits while frame low
// RL3 - Frame fall powers buffers, enables shifting
// RL4 - Standalone latches word on sixteenth active edge
// RL5 - Serial output changes on opposite clock edge
// RL6 - Readback code returns converter register next frame
// RL7 - Shift data passes out for cascading
// RL8 - Host slows clock for daisy and readback
// RL9 - Four control bits, unused low bits ignored
// RL10 - Frame rise powers down input buffers
// RL11 - Most significant bit first, control on top

`timescale 1ns/1ps

// ============================================================
// Shared constants
package dac_port_pkg;
    typedef logic [15:0] word_t;
    typedef logic [3:0]  code_t;
    typedef logic [11:0] data_t;
    typedef logic [4:0]  cnt_t;
    typedef logic [7:0]  addr_t;
    typedef logic [31:0] bus_t;
    typedef enum {LINK_IDLE, LINK_ACTIVE} link_state_e;

    localparam int    WORD_BITS  = 16;
    localparam int    CTRL_BITS  = 4;
    localparam int    DATA_BITS  = 12;
    localparam int    RESOLUTION = 12;
    localparam int    CTRL_LSB   = WORD_BITS - CTRL_BITS;
    localparam data_t DATA_MASK  = data_t'(((1 << RESOLUTION) - 1) << (DATA_BITS - RESOLUTION));

    localparam code_t CODE_LOAD      = 4'h1;
    localparam code_t CODE_READBACK  = 4'h2;
    localparam code_t CODE_EDGE_RISE = 4'h9;
    localparam code_t CODE_EDGE_FALL = 4'ha;

    localparam cnt_t  LAST_EDGE  = 5'h0f;
    localparam cnt_t  EDGE_LIMIT = 5'h10;
    localparam cnt_t  CNT_ONE    = 5'h01;
    localparam logic [3:0] RB_TOP = 4'hf;

    localparam addr_t ADDR_CTRL   = 8'h00;
    localparam addr_t ADDR_STATUS = 8'h04;
    localparam addr_t ADDR_CONV   = 8'h08;
    localparam addr_t ADDR_LAST   = 8'h0c;
    localparam addr_t ADDR_FRAMES = 8'h10;
    localparam int    CTRL_DAISY_BIT = 0;
    localparam int    STAT_RISE_BIT  = 0;
    localparam int    STAT_RB_BIT    = 1;
    localparam int    STAT_BUF_BIT   = 2;
    localparam int    STAT_DAISY_BIT = 3;

    localparam data_t CONV_RESET  = 12'h000;
    localparam word_t WORD_RESET  = 16'h0000;
    localparam logic [15:0] FRAMES_RESET = 16'h0000;
    localparam logic [15:0] FRAMES_ONE   = 16'h0001;
    localparam bus_t  BUS_ZERO    = 32'h0000_0000;
endpackage

// ============================================================
// Top module
module serial_dac_word_port (
    input  wire logic                  SYS_CLK,
    input  wire logic                  RST_N,
    input  wire logic                  WB_CYC_I,
    input  wire logic                  WB_STB_I,
    input  wire logic                  WB_WE_I,
    input  wire dac_port_pkg::addr_t   WB_ADR_I,
    input  wire logic [3:0]            WB_SEL_I,
    input  wire dac_port_pkg::bus_t    WB_DAT_I,
    output dac_port_pkg::bus_t         WB_DAT_O,
    output logic                       WB_ACK_O,
    input  wire logic                  SCLK,
    input  wire logic                  FRAME_N,
    input  wire logic                  SERIAL_INPUT_LINE,
    output logic                       SERIAL_OUTPUT_LINE,
    output dac_port_pkg::data_t        DAC_CODE,
    output logic                       BUFFERS_ON
);
    import dac_port_pkg::*;

    // ============================================================
    // Link-side shifter
    word_t       shift_word;
    word_t       hold_word;
    logic        word_tgl;
    logic        rise_sel;
    logic        rb_active;
    word_t       rb_word;

    link_shifter u_shifter (
        .sclk      (SCLK),
        .frame_n   (FRAME_N),
        .rst_n     (RST_N),
        .rise_sel  (rise_sel),
        .rb_active (rb_active),
        .rb_word   (rb_word),
        .din       (SERIAL_INPUT_LINE),
        .serial_output_line       (SERIAL_OUTPUT_LINE),
        .shift_word(shift_word),
        .hold_word (hold_word),
        .word_tgl  (word_tgl)
    );

    // ============================================================
    // Frame tracking and word decode
    logic        frame_m, frame_s, frame_d;
    logic        tgl_m, tgl_s, tgl_d;
    link_state_e state;
    logic        sel_pending;
    logic        rb_arm;
    word_t       last_word;
    logic [15:0] frames;
    logic        daisy_en;
    logic        next_frame_m, next_frame_s, next_frame_d;
    logic        next_tgl_m, next_tgl_s, next_tgl_d;
    link_state_e next_state;
    logic        next_rise_sel, next_sel_pending, next_rb_arm, next_rb_active, next_buffers_on;
    data_t       next_conv;
    word_t       next_rb_word, next_last_word;
    logic [15:0] next_frames;
    logic        frame_rise, frame_fall, take;
    word_t       taken;
    code_t       code;

    always_comb begin
        next_frame_m     = FRAME_N;
        next_frame_s     = frame_m;
        next_frame_d     = frame_s;
        next_tgl_m       = word_tgl;
        next_tgl_s       = tgl_m;
        next_tgl_d       = tgl_s;
        frame_rise       = frame_s & ~frame_d;
        frame_fall       = ~frame_s & frame_d;
        // RL4 standalone latched word
        take             = daisy_en ? frame_rise : (tgl_s ^ tgl_d);
        taken            = daisy_en ? shift_word : hold_word;
        // RL11 control field on top
        code             = taken[WORD_BITS-1:CTRL_LSB];
        next_state       = state;
        next_buffers_on  = BUFFERS_ON;
        next_conv        = DAC_CODE;
        next_sel_pending = sel_pending;
        next_rise_sel    = rise_sel;
        next_rb_arm      = rb_arm;
        next_rb_active   = rb_active;
        next_rb_word     = rb_word;
        next_last_word   = last_word;
        next_frames      = frames;
        // RL3 buffers on at frame fall
        // RL10 buffers off at frame rise
        case (state)
            LINK_IDLE: begin
                if (frame_fall) begin
                    next_state      = LINK_ACTIVE;
                    next_buffers_on = 1'b1;
                end
            end
            LINK_ACTIVE: begin
                if (frame_rise) begin
                    next_state      = LINK_IDLE;
                    next_buffers_on = 1'b0;
                    next_frames     = frames + FRAMES_ONE;
                end
            end
            default: begin
                next_state      = LINK_IDLE;
                next_buffers_on = 1'b0;
            end
        endcase
        if (take) begin
            next_last_word = taken;
            case (code)
                // RL9 unused low bits ignored
                CODE_LOAD:      next_conv        = taken[DATA_BITS-1:0] & DATA_MASK;
                CODE_READBACK:  next_rb_arm      = 1'b1;
                // RL1 edge choice by control code
                CODE_EDGE_RISE: next_sel_pending = 1'b1;
                CODE_EDGE_FALL: next_sel_pending = 1'b0;
                default:        next_rb_arm      = rb_arm;
            endcase
        end
        // RL6 readback armed for next frame
        if (frame_rise) begin
            next_rb_active = rb_arm | (take && code == CODE_READBACK);
            next_rb_arm    = 1'b0;
            next_rb_word   = {{CTRL_BITS{1'b0}}, next_conv};
        end
        // Clock select only moves while the link idles
        if (frame_s && state == LINK_IDLE) begin
            next_rise_sel = sel_pending;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            frame_m     <= 1'b1;
            frame_s     <= 1'b1;
            frame_d     <= 1'b1;
            tgl_m       <= 1'b0;
            tgl_s       <= 1'b0;
            tgl_d       <= 1'b0;
            state       <= LINK_IDLE;
            BUFFERS_ON  <= 1'b0;
            DAC_CODE    <= CONV_RESET;
            sel_pending <= 1'b0;
            rise_sel    <= 1'b0;
            rb_arm      <= 1'b0;
            rb_active   <= 1'b0;
            rb_word     <= WORD_RESET;
            last_word   <= WORD_RESET;
            frames      <= FRAMES_RESET;
        end else begin
            frame_m     <= next_frame_m;
            frame_s     <= next_frame_s;
            frame_d     <= next_frame_d;
            tgl_m       <= next_tgl_m;
            tgl_s       <= next_tgl_s;
            tgl_d       <= next_tgl_d;
            state       <= next_state;
            BUFFERS_ON  <= next_buffers_on;
            DAC_CODE    <= next_conv;
            sel_pending <= next_sel_pending;
            rise_sel    <= next_rise_sel;
            rb_arm      <= next_rb_arm;
            rb_active   <= next_rb_active;
            rb_word     <= next_rb_word;
            last_word   <= next_last_word;
            frames      <= next_frames;
        end
    end

    // ============================================================
    // Wishbone slave
    logic  next_ack, next_daisy;
    bus_t  next_dat;
    logic  req;

    always_comb begin
        req        = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
        next_ack   = req;
        next_dat   = WB_DAT_O;
        next_daisy = daisy_en;
        // Write lands on the edge that ends the acknowledge cycle
        if (WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_ADR_I == ADDR_CTRL && WB_SEL_I[0]) begin
            next_daisy = WB_DAT_I[CTRL_DAISY_BIT];
        end
        if (req && !WB_WE_I) begin
            next_dat = BUS_ZERO;
            case (WB_ADR_I)
                ADDR_CTRL:   next_dat[CTRL_DAISY_BIT] = daisy_en;
                ADDR_STATUS: begin
                    next_dat[STAT_RISE_BIT]  = rise_sel;
                    next_dat[STAT_RB_BIT]    = rb_arm | rb_active;
                    next_dat[STAT_BUF_BIT]   = BUFFERS_ON;
                    next_dat[STAT_DAISY_BIT] = daisy_en;
                end
                ADDR_CONV:   next_dat[DATA_BITS-1:0] = DAC_CODE;
                ADDR_LAST:   next_dat[WORD_BITS-1:0] = last_word;
                ADDR_FRAMES: next_dat[WORD_BITS-1:0] = frames;
                default:     next_dat = BUS_ZERO;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= BUS_ZERO;
            daisy_en <= 1'b0;
        end else begin
            WB_ACK_O <= next_ack;
            WB_DAT_O <= next_dat;
            daisy_en <= next_daisy;
        end
    end

    // ============================================================
    // Checks
    sequence frame_close_s;
        $rose(frame_s) && state == LINK_ACTIVE;
    endsequence

    sequence frame_open_s;
        $fell(frame_s) && state == LINK_IDLE;
    endsequence

    edge_default_a: assert property (@(posedge SYS_CLK) // RL1
        !$past(RST_N) && RST_N |-> !rise_sel && !sel_pending)
        else $error("edge select not falling after reset");

    buffers_up_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RL3
        frame_open_s |-> frame_fall ##1 BUFFERS_ON)
        else $error("buffers not powered at frame start");

    buffers_down_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RL10
        frame_close_s |-> frame_rise ##1 !BUFFERS_ON [*2])
        else $error("buffers not powered down at frame end");

    load_word_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RL9
        take && code == CODE_LOAD |=> DAC_CODE == ($past(taken[DATA_BITS-1:0]) & DATA_MASK))
        else $error("converter code not loaded from word");

    readback_arm_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RL6
        take && code == CODE_READBACK && !frame_rise |=> rb_arm)
        else $error("readback not armed");

    readback_go_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RL6
        rb_arm ##0 frame_close_s |=> rb_active && !rb_arm)
        else $error("readback not started for next frame");

    bus_ack_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("bus answer not exactly one cycle");
endmodule

// ===== src/link_shifter.sv
// Link-clock side: input shift register, edge counter, word capture and serial output.
// Assumes rise_sel, rb_active and rb_word change only while the frame strobe is high.
`timescale 1ns/1ps

module link_shifter (
    input  wire logic                 sclk,
    input  wire logic                 frame_n,
    input  wire logic                 rst_n,
    input  wire logic                 rise_sel,
    input  wire logic                 rb_active,
    input  wire dac_port_pkg::word_t  rb_word,
    input  wire logic                 din,
    output logic                      serial_output_line,
    output dac_port_pkg::word_t       shift_word,
    output dac_port_pkg::word_t       hold_word,
    output logic                      word_tgl
);
    import dac_port_pkg::*;

    // ============================================================
    // Active edge selection
    logic  act_clk;
    cnt_t  cnt, next_cnt;
    cnt_t  opp, next_opp;
    word_t next_shift, next_hold;
    logic  next_tgl, next_sdo;

    // RL1 falling edge unless rising chosen
    assign act_clk = rise_sel ? sclk : ~sclk;

    // ============================================================
    // Input shift on active edge
    always_comb begin
        next_shift = shift_word;
        next_hold  = hold_word;
        next_tgl   = word_tgl;
        next_cnt   = (cnt == EDGE_LIMIT) ? cnt : cnt + CNT_ONE;
        // RL2 shift while frame low
        // RL11 most significant bit first
        if (!frame_n) begin
            next_shift = {shift_word[WORD_BITS-2:0], din};
        end
        // RL4 latch on sixteenth edge
        if (!frame_n && cnt == LAST_EDGE) begin
            next_hold = {shift_word[WORD_BITS-2:0], din};
            next_tgl  = ~word_tgl;
        end
    end

    always_ff @(posedge act_clk or posedge frame_n) begin
        if (frame_n) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge act_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_word <= WORD_RESET;
            hold_word  <= WORD_RESET;
            word_tgl   <= 1'b0;
        end else begin
            shift_word <= next_shift;
            hold_word  <= next_hold;
            word_tgl   <= next_tgl;
        end
    end

    // ============================================================
    // Serial output on the opposite edge
    always_comb begin
        next_opp = (opp == EDGE_LIMIT) ? opp : opp + CNT_ONE;
        // RL5 output moves on opposite edge
        // RL7 shift data out for cascading
        next_sdo = shift_word[WORD_BITS-1];
        // RL6 converter register shifted out
        if (rb_active) begin
            next_sdo = (opp == EDGE_LIMIT) ? 1'b0 : rb_word[RB_TOP - opp[3:0]];
        end
    end

    always_ff @(negedge act_clk or posedge frame_n) begin
        if (frame_n) begin
            opp <= '0;
        end else begin
            opp <= next_opp;
        end
    end

    always_ff @(negedge act_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_output_line <= 1'b0;
        end else begin
            serial_output_line <= next_sdo;
        end
    end

    // ============================================================
    // Checks
    shift_in_a: assert property (@(posedge act_clk) disable iff (frame_n) // RL2
        cnt < LAST_EDGE |=> shift_word == {$past(shift_word[WORD_BITS-2:0]), $past(din)})
        else $error("input bit not shifted in");

    latch_16th_a: assert property (@(posedge act_clk) disable iff (frame_n) // RL4
        cnt == LAST_EDGE |=> word_tgl != $past(word_tgl) && hold_word == shift_word)
        else $error("word not latched on sixteenth edge");

    no_extra_a: assert property (@(posedge act_clk) disable iff (frame_n) // RL4
        cnt == EDGE_LIMIT |=> $stable(word_tgl) && $stable(hold_word))
        else $error("word latched after sixteenth edge");

    chain_out_a: assert property (@(negedge act_clk) disable iff (frame_n) // RL7
        !rb_active ##1 !rb_active |-> serial_output_line == $past(shift_word[WORD_BITS-1]))
        else $error("cascade output not from shift register");

    readback_out_a: assert property (@(negedge act_clk) disable iff (frame_n) // RL6
        rb_active && opp < EDGE_LIMIT |=> serial_output_line == $past(rb_word[RB_TOP - opp[3:0]]))
        else $error("readback bit wrong");
endmodule

// ===== testbench/host_link_model.sv
// Host serial master: drives frame strobe, serial clock and input line.
// Assumes the bench calls send_frame and keeps the frame gap itself.
`timescale 1ns/1ps

module host_link_model (
    output logic sclk,
    output logic frame_n,
    output logic sdi,
    input  wire logic serial_output_line,
    output int   glitches
);
    logic    tick;
    logic    act_lvl;
    realtime t_opp;

    // Idle levels land as events so the device clears its edge counters
    initial begin
        tick = 1'b0;
        act_lvl = 1'b0;
        t_opp = 0.0;
        sclk <= 1'b1;
        frame_n <= 1'b1;
        sdi <= 1'b0;
        glitches = 0;
    end

    // ============================================================
    // Frame engine, 7.5 ns ticks, serial clock still between frames
    always #3.75 tick = ~tick;

    task automatic send_frame(input logic [31:0] bits, input int n, input logic rise, input int half,
                              input int pause, output logic [31:0] rx);
        rx = '0;
        act_lvl = rise;
        sclk <= ~rise;
        repeat (4) @(posedge tick);
        frame_n <= 1'b0;
        sdi <= bits[n-1];
        repeat (pause) @(posedge tick);
        for (int i = 0; i < n; i++) begin
            repeat (half) @(posedge tick);
            if (i > 0) rx = {rx[30:0], serial_output_line};
            sclk <= rise;
            repeat (half) @(posedge tick);
            if (serial_output_line !== rx[0] && i > 0) glitches++;
            sclk <= ~rise;
            sdi <= (i + 1 < n) ? bits[n-2-i] : ~bits[0];
        end
        // one more half period, then take the last output bit and raise the frame
        repeat (half) @(posedge tick);
        rx = {rx[30:0], serial_output_line};
        frame_n <= 1'b1;
    endtask

    // output may only move on opposite edges
    always @(sclk) begin
        if (sclk !== act_lvl) begin
            t_opp = $realtime;
        end
    end

    always @(serial_output_line) begin
        if (frame_n === 1'b0 && $realtime != t_opp) begin
            glitches++;
        end
    end
endmodule

// ===== testbench/serial_dac_word_port_tb.sv
// Bench for the serial word port: Wishbone master tasks and scenario tasks.
// Assumes host_link_model as the serial master and the package constants.
`timescale 1ns/1ps

module serial_dac_word_port_tb;
    import dac_port_pkg::*;
    logic        SYS_CLK   = 1'b0;
    logic        RST_N;
    logic        WB_CYC_I  = 1'b0;
    logic        WB_STB_I  = 1'b0;
    logic        WB_WE_I   = 1'b0;
    addr_t       WB_ADR_I  = 8'h00;
    logic [3:0]  WB_SEL_I  = 4'h0;
    bus_t        WB_DAT_I  = 32'h0000_0000;
    bus_t        WB_DAT_O;
    logic        WB_ACK_O;
    logic        SCLK, FRAME_N, SERIAL_INPUT_LINE, SERIAL_OUTPUT_LINE, BUFFERS_ON;
    data_t       DAC_CODE;
    int          glitches;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          nframes = 0;
    bus_t        q;
    logic [31:0] rx;

    always #50 SYS_CLK = ~SYS_CLK;

    serial_dac_word_port i_serial_dac_word_port (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
        .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
        .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SCLK(SCLK), .FRAME_N(FRAME_N),
        .SERIAL_INPUT_LINE(SERIAL_INPUT_LINE), .SERIAL_OUTPUT_LINE(SERIAL_OUTPUT_LINE),
        .DAC_CODE(DAC_CODE), .BUFFERS_ON(BUFFERS_ON));
    host_link_model i_host_link_model (.sclk(SCLK), .frame_n(FRAME_N), .sdi(SERIAL_INPUT_LINE),
        .serial_output_line(SERIAL_OUTPUT_LINE), .glitches(glitches));

    // ============================================================
    // Shared tasks
    task automatic wrap_up;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wb(input logic we, input addr_t a, input bus_t d);
        int i;
        @(posedge SYS_CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I  <= we;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        WB_SEL_I <= 4'hf;
        for (i = 0; i < 20; i++) begin
            @(posedge SYS_CLK);
            if (WB_ACK_O === 1'b1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            wrap_up();
        end
        q = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input addr_t a, input bus_t exp);
        wb(1'b0, a, 32'h0000_0000);
        check(name, q, exp);
    endtask

    task automatic frame(input logic [31:0] bits, input int n, input logic rise, input logic slow);
        i_host_link_model.send_frame(bits, n, rise, slow ? 4 : 1, slow ? 120 : 0, rx);
        nframes++;
        repeat (8) @(posedge SYS_CLK);
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset;
        rd_chk("ctrl", ADDR_CTRL, 32'h0000_0000);
        rd_chk("status", ADDR_STATUS, 32'h0000_0000);
        rd_chk("conv", ADDR_CONV, 32'h0000_0000);
        rd_chk("frames", ADDR_FRAMES, 32'h0000_0000);
        wb(1'b1, 8'h20, 32'h0000_00ff);
        rd_chk("unmapped", 8'h20, 32'h0000_0000);
        wb(1'b1, ADDR_CONV, 32'h0000_0fff);
        rd_chk("conv ro", ADDR_CONV, 32'h0000_0000);
        check("sdo reset", {31'h0, SERIAL_OUTPUT_LINE}, 32'h0);
    endtask

    task automatic t_load;
        fork
            frame({16'h0, CODE_LOAD, 12'ha5c}, 16, 1'b0, 1'b1);
            begin
                repeat (6) @(posedge SYS_CLK);
                check("buffers on", {31'h0, BUFFERS_ON}, 32'h1);
            end
        join
        check("buffers off", {31'h0, BUFFERS_ON}, 32'h0);
        check("dac load", {20'h0, DAC_CODE}, 32'h0000_0a5c);
        rd_chk("last", ADDR_LAST, 32'h0000_1a5c);
    endtask

    task automatic t_count;
        frame({16'h0, CODE_LOAD, 12'h123}, 15, 1'b0, 1'b0);
        check("short frame", {20'h0, DAC_CODE}, 32'h0000_0a5c);
        frame({12'h0, CODE_LOAD, 12'h6e1, 4'h5}, 20, 1'b0, 1'b0);
        check("long frame", {20'h0, DAC_CODE}, 32'h0000_06e1);
        frame({16'h0, 4'h5, 12'h777}, 16, 1'b0, 1'b0);
        check("unknown code", {20'h0, DAC_CODE}, 32'h0000_06e1);
        rd_chk("last unknown", ADDR_LAST, 32'h0000_5777);
    endtask

    task automatic t_edge;
        frame({16'h0, CODE_EDGE_RISE, 12'h000}, 16, 1'b0, 1'b0);
        wb(1'b0, ADDR_STATUS, 32'h0);
        check("rise sel", {31'h0, q[STAT_RISE_BIT]}, 32'h1);
        frame({16'h0, CODE_LOAD, 12'h2b4}, 16, 1'b1, 1'b0);
        check("rise load", {20'h0, DAC_CODE}, 32'h0000_02b4);
        frame({16'h0, CODE_EDGE_FALL, 12'h000}, 16, 1'b1, 1'b0);
        frame({16'h0, CODE_LOAD, 12'h3c7}, 16, 1'b0, 1'b0);
        check("fall load", {20'h0, DAC_CODE}, 32'h0000_03c7);
    endtask

    task automatic t_readback;
        frame({16'h0, CODE_READBACK, 12'h000}, 16, 1'b0, 1'b1);
        wb(1'b0, ADDR_STATUS, 32'h0);
        check("rb armed", {31'h0, q[STAT_RB_BIT]}, 32'h1);
        frame({16'h0, 4'h5, 12'h000}, 16, 1'b0, 1'b1);
        check("readback", {16'h0, rx[15:0]}, 32'h0000_03c7);
    endtask

    task automatic t_daisy;
        wb(1'b1, ADDR_CTRL, 32'h0000_0001);
        wb(1'b0, ADDR_STATUS, 32'h0);
        check("daisy on", {31'h0, q[STAT_DAISY_BIT]}, 32'h1);
        frame(32'h1abc_1def, 32, 1'b0, 1'b1);
        check("cascade out", {16'h0, rx[16:1]}, 32'h0000_1abc);
        check("daisy load", {20'h0, DAC_CODE}, 32'h0000_0def);
        wb(1'b1, ADDR_CTRL, 32'h0000_0000);
        check("sdo edges", glitches, 0);
        rd_chk("frames", ADDR_FRAMES, 32'(nframes));
    endtask

    initial begin
        // Driven at time zero so the link side sees a reset edge
        RST_N <= 1'b0;
        repeat (4) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        repeat (4) @(posedge SYS_CLK);
        t_reset();
        t_load();
        t_count();
        t_edge();
        t_readback();
        t_daisy();
        wrap_up();
    end
endmodule
